// file: design/isc_pkg.sv
// Purpose: Shared constants for the two-wire bus control register block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Only the low half-word of each register holds fields
package isc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_BUS_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DMA_IRQ_CLK = 8'h04;
   localparam logic [15:0] BUS_CTRL_RESET = 16'h0000;
   localparam logic [15:0] DMA_IRQ_CLK_RESET = 16'h0000;
   localparam logic [15:0] BUS_CTRL_MASK = 16'hbffb;
   localparam logic [15:0] DMA_IRQ_CLK_MASK = 16'h1f7f;

   // ----------------------------------------
   // Bus control fields
   // ----------------------------------------
   localparam int B_SOFT_RESET = 15;
   localparam int B_ALERT_REQ = 13;
   localparam int B_PEC_REQ = 12;
   localparam int B_ACK_POS = 11;
   localparam int B_ACK_EN = 10;
   localparam int B_STOP_REQ = 9;
   localparam int B_START_REQ = 8;
   localparam int B_NO_STRETCH = 7;
   localparam int B_GEN_CALL = 6;
   localparam int B_PEC_EN = 5;
   localparam int B_ARP_EN = 4;
   localparam int B_SMB_ROLE = 3;
   localparam int B_SMB_MODE = 1;
   localparam int B_ENABLE = 0;

   // ----------------------------------------
   // DMA, interrupt and clock fields
   // ----------------------------------------
   localparam int B_DMA_LAST = 12;
   localparam int B_DMA_ON = 11;
   localparam int B_BUF_IE = 10;
   localparam int B_EVT_IE = 9;
   localparam int B_ERR_IE = 8;
   localparam int F_CLK_LSB = 0;
   localparam int F_CLK_W = 7;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam longint CLK_HZ = 10_000_000;
   localparam longint TIMEOUT_MS = 25;
   localparam int TIMEOUT_CYCLES = int'((TIMEOUT_MS * CLK_HZ) / 1000);

   // ----------------------------------------
   // Addresses and checksum
   // ----------------------------------------
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [7:0] PEC_POLY = 8'h07;
   localparam logic [7:0] PEC_INIT = 8'h00;
endpackage

// file: design/isc_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clock
// Notes: Level moves only when stages two and three agree
`timescale 1ns/1ns
module isc_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pin and filtered level
   input wire logic pin_in,
   output logic level_out
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         s1_ff <= RESET_LEVEL;
         s2_ff <= RESET_LEVEL;
         s3_ff <= RESET_LEVEL;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         level_out <= RESET_LEVEL;
      end else if (s2_ff == s3_ff) begin
         level_out <= s3_ff;
      end
   end
endmodule // isc_sync

// file: design/isc_pec_crc.sv
// Purpose: Bytewise CRC-8 checksum over transferred bytes
// Assumes: One byte per valid pulse, MSB first
// Notes: Cleared to the initial value by clear
`timescale 1ns/1ns
module isc_pec_crc
   import isc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic clear,
   input wire logic enable,
   // Byte stream
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   // Result
   output logic [7:0] crc_out
);
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
      end
      return c;
   endfunction

   always_ff @(posedge clock) begin
      if (rst) begin
         crc_out <= PEC_INIT;
      end else if (clear) begin
         crc_out <= PEC_INIT;
      end else if (enable && byte_valid) begin
         crc_out <= crc_step(crc_out, byte_in);
      end
   end
endmodule // isc_pec_crc

// file: design/isc_ctrl_regs.sv
// Purpose: Control registers of a two-wire bus controller with SMBus support
// Assumes: APB slave with zero wait states, pstrb selects byte lanes
// Notes: Bus engine and status flags live outside; general call and ARP address match are decoded here
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns

module isc_ctrl_regs
   import isc_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
   parameter logic [6:0] ARP_HOST_ADDR = 7'h08,
   parameter logic [6:0] ARP_DEV_ADDR = 7'h61
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link pins
   input wire logic scl_in,
   input wire logic alert_pin_i,
   output logic alert_pin_o,
   output logic alert_pin_oe,
   // Bus engine events
   input wire logic start_det,
   input wire logic stop_det,
   input wire logic pec_done,
   input wire logic alert_hw_clr,
   input wire logic rx_byte_begin,
   input wire logic dma_eot,
   input wire logic xfer_byte_valid,
   input wire logic [7:0] xfer_byte,
   input wire logic addr_valid,
   input wire logic [6:0] addr_in,
   // Flags for interrupt combine
   input wire logic start_sent_flag,
   input wire logic address_done_flag,
   input wire logic header10_sent_flag,
   input wire logic stop_detected_flag,
   input wire logic byte_done_flag,
   input wire logic tx_empty_flag,
   input wire logic rx_full_flag,
   input wire logic bus_error_flag,
   input wire logic arbitration_lost_flag,
   input wire logic no_ack_flag,
   input wire logic overrun_underrun_flag,
   input wire logic checksum_mismatch_flag,
   input wire logic alert_flag,
   // Controls to bus engine
   output logic core_reset,
   output logic peripheral_enable,
   output logic smbus_mode_switch,
   output logic smbus_role_select,
   output logic start_request,
   output logic stop_request,
   output logic stretch_allowed,
   output logic ack_reply,
   output logic pec_byte_now,
   output logic [6:0] clock_freq_mhz,
   output logic [7:0] pec_value,
   output logic gen_call_match,
   output logic arp_addr_match,
   output logic timeout_flag,
   output logic alert_line_low,
   output logic dma_request_en,
   output logic event_irq,
   output logic error_irq
);
   localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

   if (TIMEOUT_CYC < 1) begin : g_chk
      $error("TIMEOUT_CYC must be at least one");
   end

   logic [15:0] ctl0_ff;
   logic [15:0] nxt_ctl0;
   logic [15:0] ctl1_ff;
   logic [15:0] nxt_ctl1;
   logic [31:0] prdata_ff;
   logic slverr_ff;
   logic [TO_W-1:0] to_cnt_ff;
   logic to_pulse_ff;
   logic ack_next_ff;
   logic pec_next_ff;
   logic evt_irq_ff;
   logic err_irq_ff;
   logic scl_level;
   logic alert_level;
   logic setup;
   logic access;
   logic hit0;
   logic hit1;
   logic wr0;
   logic wr1;
   logic final_nack;
   logic ack_sel;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   isc_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
      .clock(clock),
      .rst(rst),
      .pin_in(scl_in),
      .level_out(scl_level)
   );

   isc_sync #(.RESET_LEVEL(1'b1)) u_alert_sync (
      .clock(clock),
      .rst(rst),
      .pin_in(alert_pin_i),
      .level_out(alert_level)
   );

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit0 = (paddr == ADDR_BUS_CTRL);
   assign hit1 = (paddr == ADDR_DMA_IRQ_CLK);
   assign wr0 = access && pwrite && hit0;
   assign wr1 = access && pwrite && hit1;
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = access && slverr_ff;

   // Read data and error captured in the setup cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
         slverr_ff <= 1'b0;
      end else if (setup) begin
         slverr_ff <= !(hit0 || hit1);
         if (pwrite || !(hit0 || hit1)) begin
            prdata_ff <= 32'h0000_0000;
         end else if (hit0) begin
            prdata_ff <= {16'h0000, ctl0_ff};
         end else begin
            prdata_ff <= {16'h0000, ctl1_ff};
         end
      end
   end

   // ----------------------------------------
   // Bus control register next value
   // ----------------------------------------
   always_comb begin
      nxt_ctl0 = ctl0_ff;
      if (wr0) begin
         if (pstrb[0]) begin
            nxt_ctl0[7:0] = pwdata[7:0] & BUS_CTRL_MASK[7:0];
         end
         if (pstrb[1]) begin
            nxt_ctl0[15:8] = pwdata[15:8] & BUS_CTRL_MASK[15:8];
         end
      end
      if (start_det) begin
         nxt_ctl0[B_START_REQ] = 1'b0;
         nxt_ctl0[B_PEC_REQ] = 1'b0;
      end
      if (stop_det) begin
         nxt_ctl0[B_STOP_REQ] = 1'b0;
         nxt_ctl0[B_PEC_REQ] = 1'b0;
      end
      if (pec_done) begin
         nxt_ctl0[B_PEC_REQ] = 1'b0;
      end
      if (alert_hw_clr) begin
         nxt_ctl0[B_ALERT_REQ] = 1'b0;
      end
      if (!nxt_ctl0[B_ENABLE]) begin
         nxt_ctl0[B_ACK_POS] = 1'b0;
         nxt_ctl0[B_ACK_EN] = 1'b0;
         nxt_ctl0[B_START_REQ] = 1'b0;
         nxt_ctl0[B_PEC_REQ] = 1'b0;
      end
      if (to_pulse_ff) begin
         nxt_ctl0[B_STOP_REQ] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctl0_ff <= BUS_CTRL_RESET;
      end else begin
         ctl0_ff <= nxt_ctl0;
      end
   end

   // ----------------------------------------
   // DMA, interrupt and clock register
   // ----------------------------------------
   always_comb begin
      nxt_ctl1 = ctl1_ff;
      if (wr1 && pstrb[0]) begin
         nxt_ctl1[7:0] = pwdata[7:0] & DMA_IRQ_CLK_MASK[7:0];
      end
      if (wr1 && pstrb[1]) begin
         nxt_ctl1[15:8] = pwdata[15:8] & DMA_IRQ_CLK_MASK[15:8];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctl1_ff <= DMA_IRQ_CLK_RESET;
      end else begin
         ctl1_ff <= nxt_ctl1;
      end
   end

   // ----------------------------------------
   // SMBus clock-low timeout
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst || core_reset || !smbus_mode_switch || !peripheral_enable || scl_level) begin
         to_cnt_ff <= '0;
         to_pulse_ff <= 1'b0;
      end else if (to_cnt_ff < TO_W'(TIMEOUT_CYC)) begin
         to_cnt_ff <= to_cnt_ff + 1'b1;
         to_pulse_ff <= (to_cnt_ff == TO_W'(TIMEOUT_CYC - 1));
      end else begin
         to_pulse_ff <= 1'b0;
      end
   end

   assign timeout_flag = to_pulse_ff;

   // ----------------------------------------
   // Acknowledge and checksum byte selection
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst || core_reset) begin
         ack_next_ff <= 1'b0;
         pec_next_ff <= 1'b0;
      end else if (rx_byte_begin) begin
         ack_next_ff <= ctl0_ff[B_ACK_EN];
         pec_next_ff <= ctl0_ff[B_PEC_REQ];
      end
   end

   assign final_nack = ctl1_ff[B_DMA_ON] && ctl1_ff[B_DMA_LAST] && dma_eot;
   assign ack_sel = ctl0_ff[B_ACK_POS] ? ack_next_ff : ctl0_ff[B_ACK_EN];
   assign ack_reply = ack_sel && !final_nack;
   assign pec_byte_now = ctl0_ff[B_ACK_POS] ? pec_next_ff : ctl0_ff[B_PEC_REQ];

   // ----------------------------------------
   // Checksum calculator
   // ----------------------------------------
   isc_pec_crc u_pec (
      .clock(clock),
      .rst(rst),
      .clear(core_reset || start_det || !ctl0_ff[B_PEC_EN]),
      .enable(ctl0_ff[B_PEC_EN]),
      .byte_valid(xfer_byte_valid),
      .byte_in(xfer_byte),
      .crc_out(pec_value)
   );

   // ----------------------------------------
   // Control outputs
   // ----------------------------------------
   assign core_reset = ctl0_ff[B_SOFT_RESET];
   assign peripheral_enable = ctl0_ff[B_ENABLE];
   assign smbus_mode_switch = ctl0_ff[B_SMB_MODE];
   assign smbus_role_select = ctl0_ff[B_SMB_ROLE];
   assign start_request = ctl0_ff[B_START_REQ];
   assign stop_request = ctl0_ff[B_STOP_REQ];
   assign stretch_allowed = !ctl0_ff[B_NO_STRETCH];
   assign clock_freq_mhz = ctl1_ff[F_CLK_LSB +: F_CLK_W];
   assign dma_request_en = ctl1_ff[B_DMA_ON];
   assign alert_pin_o = 1'b0;
   assign alert_pin_oe = ctl0_ff[B_ALERT_REQ] && peripheral_enable && !core_reset;
   assign alert_line_low = !alert_level;
   assign gen_call_match = addr_valid && ctl0_ff[B_GEN_CALL] && (addr_in == GEN_CALL_ADDR);
   assign arp_addr_match = addr_valid && ctl0_ff[B_ARP_EN] && smbus_mode_switch
      && (addr_in == (smbus_role_select ? ARP_HOST_ADDR : ARP_DEV_ADDR));

   // ----------------------------------------
   // Interrupt combine
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         evt_irq_ff <= 1'b0;
         err_irq_ff <= 1'b0;
      end else begin
         evt_irq_ff <= ctl1_ff[B_EVT_IE] && (start_sent_flag || address_done_flag || header10_sent_flag
            || stop_detected_flag || byte_done_flag
            || (ctl1_ff[B_BUF_IE] && !ctl1_ff[B_DMA_ON] && (tx_empty_flag || rx_full_flag)));
         err_irq_ff <= ctl1_ff[B_ERR_IE] && (bus_error_flag || arbitration_lost_flag || no_ack_flag
            || overrun_underrun_flag || checksum_mismatch_flag || to_pulse_ff || alert_flag);
      end
   end

   assign event_irq = evt_irq_ff;
   assign error_irq = err_irq_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_stop_on_timeout: assert property (@(posedge clock) disable iff (rst)
      to_pulse_ff |=> ctl0_ff[B_STOP_REQ])
      else $error("stop request not set after timeout");

   a_start_cleared: assert property (@(posedge clock) disable iff (rst)
      start_det |=> !ctl0_ff[B_START_REQ])
      else $error("start request survived start detection");

   a_pec_cleared: assert property (@(posedge clock) disable iff (rst)
      (pec_done || stop_det) |=> !ctl0_ff[B_PEC_REQ])
      else $error("checksum request survived its clear event");

   a_disable_clears: assert property (@(posedge clock) disable iff (rst)
      !ctl0_ff[B_ENABLE] |-> (ctl0_ff[12:10] == 3'b000) && !ctl0_ff[B_START_REQ])
      else $error("disabled block holds ack or request bits");

   a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      ((ctl0_ff & ~BUS_CTRL_MASK) == 16'h0000) && ((ctl1_ff & ~DMA_IRQ_CLK_MASK) == 16'h0000))
      else $error("reserved bit set");

   a_half_write: assert property (@(posedge clock) disable iff (rst)
      (wr1 && pstrb[0] && !pstrb[1]) |=> (ctl1_ff[15:8] == $past(ctl1_ff[15:8])))
      else $error("byte lane outside strobe was written");

   a_timeout_count: assert property (@(posedge clock) disable iff (rst)
      $rose(to_pulse_ff) |-> (to_cnt_ff == TO_W'(TIMEOUT_CYC)) && !scl_level)
      else $error("timeout raised at wrong count");

   a_alert_drive: assert property (@(posedge clock) disable iff (rst)
      alert_pin_oe |-> ctl0_ff[B_ALERT_REQ] && !alert_pin_o)
      else $error("alert pin driven without request");

   a_buf_irq_gate: assert property (@(posedge clock) disable iff (rst)
      (tx_empty_flag && ctl1_ff[B_EVT_IE] && ctl1_ff[B_BUF_IE] && !ctl1_ff[B_DMA_ON]) |=> event_irq)
      else $error("buffer interrupt missing");

   a_err_irq_gate: assert property (@(posedge clock) disable iff (rst)
      !ctl1_ff[B_ERR_IE] |=> !error_irq)
      else $error("error interrupt while disabled");

   a_dma_last_nack: assert property (@(posedge clock) disable iff (rst)
      final_nack |-> !ack_reply)
      else $error("ACK sent after final DMA byte");
endmodule // isc_ctrl_regs

// file: sim/isc_far_side.sv
// Purpose: Far-side two-wire party model for the control block
// Assumes: Both lines are pulled up when released
// Notes: Clock line toggles only inside frames
`timescale 1ns/1ns
module isc_far_side (
   // Bench commands
   input wire logic frame_on,
   input wire logic hold_low,
   // Block pins
   input wire logic alert_pin_o,
   input wire logic alert_pin_oe,
   output logic scl_line,
   output logic alert_line
);
   logic sck;
   initial begin
      sck = 1'b1;
      forever begin
         #400;
         sck = frame_on ? ~sck : 1'b1;
      end
   end
   // Released lines go high through the pull-ups
   assign scl_line = sck & ~hold_low;
   assign alert_line = alert_pin_oe ? alert_pin_o : 1'b1;
endmodule // isc_far_side

// file: sim/tb.sv
// Purpose: Self-checking bench for the two-wire control registers
// Assumes: Zero-wait APB slave, short timeout parameter
// Notes: Reads are checked from a queue of expected words
`timescale 1ns/1ns
module tb;
   import isc_pkg::*;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, xbv, addr_valid, frame_on, hold_low;
   logic [7:0] paddr, xfer_byte, pec_value, crc;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [5:0] ev;
   logic [12:0] fl;
   logic [6:0] addr_in, clock_freq_mhz, code;
   logic alert_pin_o, alert_pin_oe, scl_line, alert_line, to_seen;
   logic core_reset, peripheral_enable, smbus_mode_switch, smbus_role_select, start_request, stop_request;
   logic stretch_allowed, ack_reply, gen_call_match, timeout_flag, alert_line_low;
   logic dma_request_en, event_irq, error_irq, pec_byte_now, arp_addr_match;
   localparam logic [6:0] ARP_H = 7'h08;
   localparam logic [6:0] ARP_D = 7'h61;
   logic [32:0] q[$];
   logic [15:0] hv[4] = '{16'h1101, 16'h0201, 16'h1001, 16'h2001};
   logic [7:0] pv[3] = '{8'h03, 8'h07, 8'h04};
   int failures = 0;
   int comparisons = 0;
   int cyc = 0;
   int i, k;

   isc_ctrl_regs #(.TIMEOUT_CYC(20), .ARP_HOST_ADDR(ARP_H), .ARP_DEV_ADDR(ARP_D)) uut (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_line), .alert_pin_i(alert_line), .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe),
      .start_det(ev[0]), .stop_det(ev[1]), .pec_done(ev[2]), .alert_hw_clr(ev[3]), .rx_byte_begin(ev[4]),
      .dma_eot(ev[5]), .xfer_byte_valid(xbv), .xfer_byte(xfer_byte), .addr_valid(addr_valid),
      .addr_in(addr_in), .start_sent_flag(fl[0]), .address_done_flag(fl[1]), .header10_sent_flag(fl[2]),
      .stop_detected_flag(fl[3]), .byte_done_flag(fl[4]), .tx_empty_flag(fl[5]), .rx_full_flag(fl[6]),
      .bus_error_flag(fl[7]), .arbitration_lost_flag(fl[8]), .no_ack_flag(fl[9]),
      .overrun_underrun_flag(fl[10]), .checksum_mismatch_flag(fl[11]), .alert_flag(fl[12]),
      .core_reset(core_reset), .peripheral_enable(peripheral_enable), .smbus_mode_switch(smbus_mode_switch),
      .smbus_role_select(smbus_role_select), .start_request(start_request), .stop_request(stop_request),
      .stretch_allowed(stretch_allowed), .ack_reply(ack_reply), .pec_byte_now(pec_byte_now),
      .clock_freq_mhz(clock_freq_mhz), .pec_value(pec_value), .gen_call_match(gen_call_match),
      .arp_addr_match(arp_addr_match), .timeout_flag(timeout_flag), .alert_line_low(alert_line_low),
      .dma_request_en(dma_request_en), .event_irq(event_irq), .error_irq(error_irq)
   );

   isc_far_side far (
      .frame_on(frame_on), .hold_low(hold_low), .alert_pin_o(alert_pin_o),
      .alert_pin_oe(alert_pin_oe), .scl_line(scl_line), .alert_line(alert_line)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Counts: %0d failures, %0d comparisons", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Holds the request until pready is sampled, then idles one cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      {psel, penable} <= 2'b00;
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, a, d, s);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      q.push_back(e);
      apb(1'b0, a, 32'h0000_0000, 4'hf);
   endtask

   task automatic pulse(input int n);
      ev[n] <= 1'b1;
      @(posedge clock);
      ev[n] <= 1'b0;
      @(posedge clock);
   endtask

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int j = 0; j < 8; j++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
      return x;
   endfunction

   // ----------------------------------------
   // Clock, read monitor and hang limit
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (timeout_flag === 1'b1) to_seen = 1'b1;
      if (psel && penable && pready && !pwrite) check({pslverr, prdata}, q.pop_front());
      if (cyc == 20000) begin
         failures++;
         complete_run();
      end
   end

   initial begin
      {psel, penable, pwrite, xbv, addr_valid, frame_on, hold_low, rst, to_seen} = 9'h002;
      {paddr, pwdata, pstrb, ev, fl, addr_in, xfer_byte} = '0;
      k = $urandom(32'hf90f_42be);
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(ADDR_BUS_CTRL, 33'h0);
      rd(ADDR_DMA_IRQ_CLK, 33'h0);
      rd(8'h08, 33'h1_0000_0000);
      wr(8'h08, 32'hffff_ffff, 4'hf);
      check(stretch_allowed, 1'b1);
      wr(ADDR_BUS_CTRL, 32'hffff_ffff, 4'hf);
      rd(ADDR_BUS_CTRL, 33'h0_0000_bffb);
      check({core_reset, smbus_mode_switch, smbus_role_select, stretch_allowed, peripheral_enable}, 5'h1d);
      wr(ADDR_BUS_CTRL, 32'h0000_1f00, 4'hf);
      rd(ADDR_BUS_CTRL, 33'h0_0000_0200);
      wr(ADDR_DMA_IRQ_CLK, 32'hffff_ffff, 4'h3);
      rd(ADDR_DMA_IRQ_CLK, 33'h0_0000_1f7f);
      check(dma_request_en, 1'b1);
      code = 7'(2 + $urandom % 71);
      wr(ADDR_DMA_IRQ_CLK, {25'h0, code}, 4'h1);
      rd(ADDR_DMA_IRQ_CLK, {25'h0_0000_1f, 1'b0, code});
      check(clock_freq_mhz, code);
      for (i = 0; i < 4; i++) begin
         wr(ADDR_BUS_CTRL, {16'h0, hv[i]}, 4'hf);
         check({start_request, stop_request}, {hv[i][8], hv[i][9]});
         if (i == 3) begin
            check(alert_pin_oe, 1'b1);
            check({pready, alert_pin_o}, 2'b10);
            repeat (6) @(posedge clock);
            check(alert_line_low, 1'b1);
         end
         pulse(i);
         rd(ADDR_BUS_CTRL, 33'h1);
      end
      check(alert_pin_oe, 1'b0);
      wr(ADDR_BUS_CTRL, 32'h0000_0c01, 4'hf);
      pulse(4);
      wr(ADDR_BUS_CTRL, 32'h0000_0801, 4'hf);
      check(ack_reply, 1'b1);
      pulse(4);
      check(ack_reply, 1'b0);
      wr(ADDR_BUS_CTRL, 32'h0000_0441, 4'hf);
      addr_valid <= 1'b1;
      @(negedge clock);
      check(gen_call_match, 1'b1);
      check(ack_reply, 1'b1);
      @(posedge clock);
      wr(ADDR_DMA_IRQ_CLK, 32'h0000_1800, 4'h2);
      ev[5] <= 1'b1;
      @(negedge clock);
      check(ack_reply, 1'b0);
      @(posedge clock);
      ev[5] <= 1'b0;
      wr(ADDR_BUS_CTRL, 32'h0000_0401, 4'hf);
      check(gen_call_match, 1'b0);
      wr(ADDR_BUS_CTRL, 32'h0000_101b, 4'hf);
      addr_in <= ARP_H;
      @(negedge clock);
      check({arp_addr_match, pec_byte_now}, 2'b11);
      @(posedge clock);
      addr_in <= ARP_D;
      @(negedge clock);
      check(arp_addr_match, 1'b0);
      @(posedge clock);
      wr(ADDR_BUS_CTRL, 32'h0000_0013, 4'hf);
      check(arp_addr_match, 1'b1);
      for (i = 0; i < 3; i++) begin
         wr(ADDR_DMA_IRQ_CLK, {16'h0, pv[i], 8'h0}, 4'h2);
         for (k = 0; k < 13; k++) begin
            fl[k] <= 1'b1;
            @(posedge clock);
            @(negedge clock);
            check(event_irq, pv[i][1] & (k < 5 | (k < 7 & pv[i][2])));
            check(error_irq, pv[i][0] & (k > 6));
            @(posedge clock);
            fl[k] <= 1'b0;
            @(posedge clock);
         end
      end
      wr(ADDR_BUS_CTRL, 32'h0000_0003, 4'hf);
      frame_on <= 1'b1;
      repeat (40) @(posedge clock);
      check(to_seen, 1'b0);
      frame_on <= 1'b0;
      hold_low <= 1'b1;
      repeat (60) if (to_seen !== 1'b1) @(posedge clock);
      @(negedge clock);
      check(to_seen, 1'b1);
      check(stop_request, 1'b1);
      @(posedge clock);
      hold_low <= 1'b0;
      wr(ADDR_BUS_CTRL, 32'h0000_0021, 4'hf);
      pulse(0);
      crc = 8'h00;
      xbv <= 1'b1;
      for (i = 0; i < 3; i++) begin
         xfer_byte <= 8'($urandom);
         @(posedge clock);
         crc = crc_step(crc, xfer_byte);
      end
      xbv <= 1'b0;
      @(negedge clock);
      check(pec_value, crc);
      @(posedge clock);
      wr(ADDR_BUS_CTRL, 32'h0000_0001, 4'hf);
      @(negedge clock);
      check(pec_value, 8'h00);
      complete_run();
   end
endmodule // tb
